// >>> include/qsw_pkg.sv
// Purpose: shared constants and types of the serial write host
// Assumes: 100 MHz core clock; host makes the serial clock
// Notes:   offsets are byte addresses of the command port
package qsw_pkg;
	typedef enum logic [1:0] {QSW_SINGLE, QSW_DUAL, QSW_QUAD} qsw_mode_t;
	typedef enum logic [3:0] {
		QSW_K_OPCODE, QSW_K_RST_ARM, QSW_K_RST, QSW_K_WRITE_ENABLE_CMD, QSW_K_WRITE,
		QSW_K_DUAL_DATA_WRITE, QSW_K_QUAD_DATA_WRITE, QSW_K_DUAL_ADDR_DATA_WRITE,
		QSW_K_QUAD_ADDR_DATA_WRITE, QSW_K_CLK_REG_READ, QSW_K_RECOVER,
		QSW_K_XIP_EXIT
	} qsw_kind_t;
	typedef enum logic [2:0] {
		QSW_ST_IDLE, QSW_ST_LOAD, QSW_ST_LOW, QSW_ST_HIGH, QSW_ST_DONE
	} qsw_state_t;

	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_CFG   = 8'h04;
	localparam logic [7:0] OFS_ADDR  = 8'h08;
	localparam logic [7:0] OFS_OPC   = 8'h0C;
	localparam logic [7:0] OFS_TX    = 8'h10;
	localparam logic [7:0] OFS_RX    = 8'h14;
	localparam logic [7:0] OFS_STAT  = 8'h18;

	localparam int CTRL_KIND_LSB = 0;
	localparam int CTRL_START    = 4;
	localparam int CTRL_STOP     = 5;
	localparam int CTRL_CLR_ERR  = 6;
	localparam int CFG_MODE_LSB  = 0;
	localparam int CFG_QE        = 2;
	localparam int CFG_XIP       = 3;

	localparam int ADDR_W          = 17;
	localparam logic [7:0] FF_BYTE = 8'hFF;
	localparam int CLK_MHZ         = 100;
	localparam int FAST_SCK_MHZ    = 108;
	localparam int RTC_SCK_MHZ     = 40;
	localparam logic [1:0] FAST_HALF =
		2'((CLK_MHZ + 2 * FAST_SCK_MHZ - 1) / (2 * FAST_SCK_MHZ));
	localparam logic [1:0] RTC_HALF  =
		2'((CLK_MHZ + 2 * RTC_SCK_MHZ - 1) / (2 * RTC_SCK_MHZ));

	typedef struct packed {
		qsw_state_t  st;
		qsw_mode_t   mode;
		qsw_kind_t   kind;
		logic        qe;
		logic        continuous_read_mode;
		logic        write_latch_bit;
		logic        armed;
		logic        err;
		logic        stop;
		logic        txv;
		logic        rxv;
		logic [16:0] addr;
		logic [7:0]  opc;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic [7:0]  sh;
		logic [3:0]  beats;
		logic [2:0]  idx;
		logic [1:0]  div;
		logic [11:0] cnt;
		logic        sck;
		logic        cs_n;
		logic [3:0]  io_o;
		logic [3:0]  io_oe_n;
		logic [3:0]  s1;
		logic [3:0]  s2;
		logic [31:0] rdata;
	} qsw_regs_t;
endpackage

// >>> core/qsw_host.sv
// Purpose: host that drives the serial nvSRAM write, reset and clock-register read
// Assumes: serial clock mode 0; data pins sampled through two flip-flops
// Notes:   software streams data bytes one at a time through TX and RX
// How it works
// - single-line write, one bit per clock
// - dual-line write, bit 7 on I/O1
// - quad-line write, bit 7 on I/O3
// - quad mode needs quad enable set
// - dual data write: data on two lines
// - quad data write: data on four lines
// - dual address write: address two lines
// - quad address write: address four lines
// - leave continuous read before any write
// - reset needs reset_arm directly before
// - eight clocks all high restore single
// - clock register read: address, then bytes, 25 MHz (40 MHz limit)
// - software sets and clears read hold
// - writes need write latch set first
//
// Strobed register access and the address map were left to the implementer.
module qsw_host #(
	parameter int RESET_NS  = 1000,
	parameter int CS_GAP_NS = 50
) (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wr_data_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rd_data_out,
	output logic             sck_out,
	output logic             cs_n_out,
	input  wire logic [3:0]  io_in,
	output logic      [3:0]  io_out,
	output logic      [3:0]  io_oe_n_out
);
	localparam logic [11:0] RST_CYC =
		12'((RESET_NS * qsw_pkg::CLK_MHZ + 999) / 1000);
	localparam logic [11:0] GAP_CYC =
		12'((CS_GAP_NS * qsw_pkg::CLK_MHZ + 999) / 1000);
	// Enum fields named so that no untyped zero lands on them
	localparam qsw_pkg::qsw_regs_t RST_VAL = '{st: qsw_pkg::QSW_ST_IDLE,
		mode: qsw_pkg::QSW_SINGLE, kind: qsw_pkg::QSW_K_OPCODE, cs_n: 1'b1, io_oe_n: 4'hF,
		default: '0};

	qsw_pkg::qsw_regs_t r_reg;
	qsw_pkg::qsw_regs_t r_next;

	// Lane code: 0 one line, 1 two lines, 2 four lines
	function automatic logic [1:0] lanes(input qsw_pkg::qsw_kind_t k,
		input qsw_pkg::qsw_mode_t m, input logic [2:0] i);
		case (k)
			qsw_pkg::QSW_K_DUAL_DATA_WRITE: lanes = (i > 3'd3) ? 2'd1 : 2'd0;
			qsw_pkg::QSW_K_QUAD_DATA_WRITE: lanes = (i > 3'd3) ? 2'd2 : 2'd0;
			qsw_pkg::QSW_K_DUAL_ADDR_DATA_WRITE: lanes = (i > 3'd0) ? 2'd1 : 2'd0;
			qsw_pkg::QSW_K_QUAD_ADDR_DATA_WRITE: lanes = (i > 3'd0) ? 2'd2 : 2'd0;
			qsw_pkg::QSW_K_RECOVER: lanes = 2'd0;
			default: begin
				case (m)
					qsw_pkg::QSW_DUAL: lanes = 2'd1;
					qsw_pkg::QSW_QUAD: lanes = 2'd2;
					default: lanes = 2'd0;
				endcase
			end
		endcase
	endfunction

	function automatic logic [2:0] naddr(input qsw_pkg::qsw_kind_t k);
		if (k == qsw_pkg::QSW_K_CLK_REG_READ) begin
			naddr = 3'd1;
		end else if (is_write(k)) begin
			naddr = 3'd3;
		end else begin
			naddr = 3'd0;
		end
	endfunction

	function automatic logic is_write(input qsw_pkg::qsw_kind_t k);
		is_write = k inside {qsw_pkg::QSW_K_WRITE, qsw_pkg::QSW_K_DUAL_DATA_WRITE,
			qsw_pkg::QSW_K_QUAD_DATA_WRITE, qsw_pkg::QSW_K_DUAL_ADDR_DATA_WRITE,
			qsw_pkg::QSW_K_QUAD_ADDR_DATA_WRITE};
	endfunction

	// Most significant bits go out first on the highest lane
	function automatic logic [3:0] drive(input logic [7:0] b, input logic [1:0] l);
		case (l)
			2'd1: drive = {2'b00, b[7:6]};
			2'd2: drive = b[7:4];
			default: drive = {3'b000, b[7]};
		endcase
	endfunction

	function automatic logic [3:0] enables(input logic [1:0] l);
		case (l)
			2'd1: enables = 4'hC;
			2'd2: enables = 4'h0;
			default: enables = 4'hE;
		endcase
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] b, input logic [3:0] s,
		input logic [1:0] l);
		case (l)
			2'd1: shift_in = {b[5:0], s[1:0]};
			2'd2: shift_in = {b[3:0], s};
			default: shift_in = {b[6:0], s[1]};
		endcase
	endfunction

	always_comb begin
		logic [1:0] ln;
		logic [1:0] half;
		logic [7:0] nb;
		logic [7:0] shd;
		logic       rd;
		logic       go;
		logic       fin;
		logic       wk;
		logic       ext;
		logic       needq;
		logic       refuse;
		qsw_pkg::qsw_kind_t k;
		ln = lanes(r_reg.kind, r_reg.mode, r_reg.idx);
		half = (r_reg.kind == qsw_pkg::QSW_K_CLK_REG_READ) ? qsw_pkg::RTC_HALF
			: qsw_pkg::FAST_HALF;
		rd = (r_reg.kind == qsw_pkg::QSW_K_CLK_REG_READ) && (r_reg.idx > naddr(r_reg.kind));
		shd = shift_in(r_reg.sh, r_reg.s2, ln);
		nb = 8'h00;
		go = 1'b0;
		fin = 1'b0;
		k = qsw_pkg::qsw_kind_t'(wr_data_in[qsw_pkg::CTRL_KIND_LSB +: 4]);
		wk = is_write(k);
		ext = wk && (k != qsw_pkg::QSW_K_WRITE);
		needq = (r_reg.mode == qsw_pkg::QSW_QUAD || k == qsw_pkg::QSW_K_QUAD_DATA_WRITE
			|| k == qsw_pkg::QSW_K_QUAD_ADDR_DATA_WRITE) && (k != qsw_pkg::QSW_K_RECOVER);
		refuse = 1'b0;
		r_next = r_reg;
		r_next.s1 = io_in;
		r_next.s2 = r_reg.s1;
		r_next.rdata = 32'h0000_0000;
		if (rd_in && addr_in == qsw_pkg::OFS_RX) begin
			r_next.rxv = 1'b0;
		end

		case (r_reg.st)
			qsw_pkg::QSW_ST_LOAD: begin
				if (r_reg.idx == 3'd0) begin
					// non-A mode byte, FF on the active lines (all four for recover)
					nb = (r_reg.kind == qsw_pkg::QSW_K_RECOVER
						|| r_reg.kind == qsw_pkg::QSW_K_XIP_EXIT) ? qsw_pkg::FF_BYTE : r_reg.opc;
					go = 1'b1;
				end else if (r_reg.idx <= naddr(r_reg.kind)) begin
					go = 1'b1;
					if (rd) begin
						nb = 8'h00;
					end else if (r_reg.kind == qsw_pkg::QSW_K_CLK_REG_READ) begin
						nb = r_reg.addr[7:0];
					end else if (r_reg.idx == 3'd1) begin
						nb = {7'h00, r_reg.addr[16]};
					end else if (r_reg.idx == 3'd2) begin
						nb = r_reg.addr[15:8];
					end else begin
						nb = r_reg.addr[7:0];
					end
				end else if (is_write(r_reg.kind) || r_reg.kind == qsw_pkg::QSW_K_OPCODE) begin
					if (r_reg.txv) begin
						nb = r_reg.tx;
						r_next.txv = 1'b0;
						go = 1'b1;
					end else if (r_reg.stop) begin
						fin = 1'b1;
					end
				end else if (r_reg.kind == qsw_pkg::QSW_K_CLK_REG_READ) begin
					if (r_reg.stop) begin
						fin = 1'b1;
					end else if (!r_reg.rxv) begin
						go = 1'b1;
					end
				end else begin
					fin = 1'b1;
				end
				if (go) begin
					r_next.sh = nb;
					r_next.beats = 4'd8 >> ln;
					r_next.div = 2'd0;
					r_next.st = qsw_pkg::QSW_ST_LOW;
					r_next.io_o = drive(nb, ln);
					r_next.io_oe_n = rd ? 4'hF : enables(ln);
					if (r_reg.kind == qsw_pkg::QSW_K_RECOVER) begin
						r_next.io_o = 4'hF;
						r_next.io_oe_n = 4'h0;
					end
				end
				if (fin) begin
					r_next.st = qsw_pkg::QSW_ST_DONE;
					r_next.cs_n = 1'b1;
					r_next.io_oe_n = 4'hF;
					r_next.cnt = GAP_CYC;
					r_next.armed = (r_reg.kind == qsw_pkg::QSW_K_RST_ARM);
					case (r_reg.kind)
						qsw_pkg::QSW_K_WRITE_ENABLE_CMD: r_next.write_latch_bit = 1'b1;
						qsw_pkg::QSW_K_RST: begin
							r_next.mode = qsw_pkg::QSW_SINGLE;
							r_next.write_latch_bit = 1'b0;
							r_next.continuous_read_mode = 1'b0;
							r_next.cnt = RST_CYC;
						end
						qsw_pkg::QSW_K_RECOVER: r_next.mode = qsw_pkg::QSW_SINGLE;
						qsw_pkg::QSW_K_XIP_EXIT: r_next.continuous_read_mode = 1'b0;
						default: ;
					endcase
				end
			end
			qsw_pkg::QSW_ST_LOW: begin
				if (r_reg.div == half - 2'd1) begin
					r_next.div = 2'd0;
					r_next.sck = 1'b1;
					r_next.st = qsw_pkg::QSW_ST_HIGH;
				end else begin
					r_next.div = r_reg.div + 2'd1;
				end
			end
			qsw_pkg::QSW_ST_HIGH: begin
				// Sampling late in the high half covers the synchroniser delay
				if (r_reg.div == half - 2'd1) begin
					r_next.div = 2'd0;
					r_next.sck = 1'b0;
					r_next.sh = shd;
					r_next.beats = r_reg.beats - 4'd1;
					if (r_reg.beats == 4'd1) begin
						if (rd) begin
							r_next.rx = shd;
							r_next.rxv = 1'b1;
						end
						r_next.idx = (r_reg.idx == 3'd4) ? 3'd4 : r_reg.idx + 3'd1;
						r_next.st = qsw_pkg::QSW_ST_LOAD;
					end else begin
						r_next.st = qsw_pkg::QSW_ST_LOW;
						if (r_reg.kind != qsw_pkg::QSW_K_RECOVER) begin
							r_next.io_o = drive(shd, ln);
						end
					end
				end else begin
					r_next.div = r_reg.div + 2'd1;
				end
			end
			qsw_pkg::QSW_ST_DONE: begin
				if (r_reg.cnt == 12'd0) begin
					r_next.st = qsw_pkg::QSW_ST_IDLE;
				end else begin
					r_next.cnt = r_reg.cnt - 12'd1;
				end
			end
			default: begin
				r_next.sck = 1'b0;
				r_next.cs_n = 1'b1;
				r_next.io_oe_n = 4'hF;
			end
		endcase

		if (wr_in) begin
			if (addr_in == qsw_pkg::OFS_CTRL) begin
				if (wr_data_in[qsw_pkg::CTRL_START]) begin
					refuse = (r_reg.st != qsw_pkg::QSW_ST_IDLE) || (wk && !r_reg.write_latch_bit);
					refuse = refuse || (wk && r_reg.continuous_read_mode);
					refuse = refuse || (needq && !r_reg.qe);
					refuse = refuse || (ext && r_reg.mode != qsw_pkg::QSW_SINGLE);
					refuse = refuse || (k == qsw_pkg::QSW_K_RST && !r_reg.armed);
					refuse = refuse || (k > qsw_pkg::QSW_K_XIP_EXIT);
					if (!refuse) begin
						r_next.kind = k;
						r_next.idx = 3'd0;
						r_next.stop = 1'b0;
						r_next.cs_n = 1'b0;
						r_next.st = qsw_pkg::QSW_ST_LOAD;
					end
				end
				if (wr_data_in[qsw_pkg::CTRL_STOP]) begin
					r_next.stop = 1'b1;
				end
				r_next.err = (r_reg.err && !wr_data_in[qsw_pkg::CTRL_CLR_ERR]) || refuse;
			end else if (addr_in == qsw_pkg::OFS_CFG) begin
				if (r_reg.st == qsw_pkg::QSW_ST_IDLE) begin
					r_next.mode = qsw_pkg::qsw_mode_t'(wr_data_in[qsw_pkg::CFG_MODE_LSB +: 2]);
					r_next.qe = wr_data_in[qsw_pkg::CFG_QE];
					r_next.continuous_read_mode = wr_data_in[qsw_pkg::CFG_XIP];
				end
			end else if (addr_in == qsw_pkg::OFS_ADDR) begin
				r_next.addr = wr_data_in[qsw_pkg::ADDR_W - 1:0];
			end else if (addr_in == qsw_pkg::OFS_OPC) begin
				r_next.opc = wr_data_in[7:0];
			end else if (addr_in == qsw_pkg::OFS_TX) begin
				r_next.tx = wr_data_in[7:0];
				r_next.txv = 1'b1;
			end
		end

		if (rd_in) begin
			if (addr_in == qsw_pkg::OFS_CTRL) begin
				r_next.rdata = {28'h0000000, r_reg.kind};
			end else if (addr_in == qsw_pkg::OFS_CFG) begin
				r_next.rdata = {28'h0000000, r_reg.continuous_read_mode, r_reg.qe, r_reg.mode};
			end else if (addr_in == qsw_pkg::OFS_ADDR) begin
				r_next.rdata = {15'h0000, r_reg.addr};
			end else if (addr_in == qsw_pkg::OFS_OPC) begin
				r_next.rdata = {24'h000000, r_reg.opc};
			end else if (addr_in == qsw_pkg::OFS_TX) begin
				r_next.rdata = {24'h000000, r_reg.tx};
			end else if (addr_in == qsw_pkg::OFS_RX) begin
				r_next.rdata = {24'h000000, r_reg.rx};
			end else if (addr_in == qsw_pkg::OFS_STAT) begin
				r_next.rdata = {26'h0000000, r_reg.armed, r_reg.write_latch_bit, r_reg.err, r_reg.rxv,
					r_reg.txv, r_reg.st != qsw_pkg::QSW_ST_IDLE};
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r_reg <= RST_VAL;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rd_data_out = r_reg.rdata;
	assign sck_out = r_reg.sck;
	assign cs_n_out = r_reg.cs_n;
	assign io_out = r_reg.io_o;
	assign io_oe_n_out = r_reg.io_oe_n;
endmodule

// >>> testbench/qsw_host_properties.sv
// Purpose: port-level properties of the serial write host
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   offset 1Ch lies outside the register map
module qsw_host_checker (
	input wire logic        ref_clk_in,
	input wire logic        rst_n_in,
	input wire logic [7:0]  addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rd_data_out,
	input wire logic        sck_out,
	input wire logic        cs_n_out,
	input wire logic [3:0]  io_in,
	input wire logic [3:0]  io_out,
	input wire logic [3:0]  io_oe_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	AST_SCK_IDLE: assert property (cs_n_out |-> !sck_out)
		else $error("serial clock active while deselected");
	AST_OE_IDLE: assert property (cs_n_out |-> io_oe_n_out == 4'hF)
		else $error("pins driven while deselected");
	AST_CS_GAP: assert property ($rose(cs_n_out) |=> cs_n_out)
		else $error("select gap too short");
	AST_SETUP: assert property ($fell(cs_n_out) |-> !sck_out ##1 !sck_out)
		else $error("clock rose too soon after select");
	AST_IO_STABLE: assert property (sck_out |-> $stable(io_out) && $stable(io_oe_n_out))
		else $error("data changed while clock high");
	AST_SCK_PULSE: assert property ($rose(sck_out) |-> ##[1:2] !sck_out)
		else $error("clock high phase too long");
	AST_RD_IDLE: assert property (!$past(rd_in) |-> rd_data_out == 32'h0)
		else $error("read data outside read slot");
	AST_UNMAPPED: assert property (rd_in && addr_in == 8'h1C |=> rd_data_out == 32'h0)
		else $error("unmapped read not zero");
	COV_FRAME: cover property ($fell(cs_n_out));
	COV_QUAD: cover property (sck_out && io_oe_n_out == 4'h0);
	COV_READ: cover property (sck_out && !cs_n_out && io_oe_n_out == 4'hF);
endmodule
bind qsw_host qsw_host_checker u_qsw_host_checker (.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
	.rd_in(rd_in), .rd_data_out(rd_data_out), .sck_out(sck_out), .cs_n_out(cs_n_out),
	.io_in(io_in), .io_out(io_out), .io_oe_n_out(io_oe_n_out));

// >>> testbench/qsw_dev_model.sv
// Purpose: behavioural nvSRAM side of the serial link
// Assumes: mode 0 clock; all four lines pulled up
// Notes:   records the first 64 beats; answers only clock register reads
module qsw_dev_model #(
	parameter logic [7:0] RTC_OPC = 8'h56
) (
	input  wire logic       sck_in,
	input  wire logic       cs_n_in,
	input  wire logic [3:0] io_out_in,
	input  wire logic [3:0] io_oe_n_in,
	output logic      [3:0] io_in_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  cap [0:63];
	int          ncap = 0;
	int          k;
	logic [15:0] sh;
	logic [3:0]  a;
	logic [7:0]  rv;
	logic        so_en = 1'b0;
	logic        so_val = 1'b0;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io_in_out[i] = !io_oe_n_in[i] ? io_out_in[i] : (so_en && i == 1) ? so_val : 1'b1;
		end
	end
	always @(negedge cs_n_in) begin
		ncap = 0;
	end
	// Released output floats to pull-up
	always @(posedge cs_n_in) begin
		so_en = 1'b0;
	end
	// model never busy, so resets always taken
	always @(posedge sck_in) begin
		if (!cs_n_in && ncap < 64) begin
			cap[ncap] = io_in_out;
			if (ncap < 16)
				sh = {sh[14:0], io_in_out[0]};
			ncap++;
		end
	end
	always @(negedge sck_in) begin
		if (!cs_n_in && ncap >= 16 && sh[15:8] == RTC_OPC) begin
			k = ncap - 16;
			a = sh[3:0] + 4'(k / 8);
			rv = 8'(8'h30 + 8'h11 * a);
			so_val = rv[7 - k % 8];
			so_en = 1'b1;
		end
	end
endmodule

// >>> testbench/qsw_host_test.sv
// Purpose: self-checking bench of the serial write host
// Assumes: device model on the far side of the link
// Notes:   short reset and gap parameters keep the run brief
module qsw_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0]  A_CTL = qsw_pkg::OFS_CTRL;
	localparam logic [7:0]  A_CFG = qsw_pkg::OFS_CFG;
	localparam logic [7:0]  A_ST  = qsw_pkg::OFS_STAT;
	localparam logic [7:0]  A_TX  = qsw_pkg::OFS_TX;
	localparam logic [39:0] SGL   = 40'h02_01_23_45_A5;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        sck;
	logic        cs_n;
	logic [3:0]  io_i;
	logic [3:0]  io_o;
	logic [3:0]  io_oe_n;
	logic [31:0] v;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          al;
	int          dl;
	always #5 clk = ~clk;
	qsw_host #(.RESET_NS(10), .CS_GAP_NS(10)) u_qsw_host (.ref_clk_in(clk), .rst_n_in(rst_n),
		.addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
		.sck_out(sck), .cs_n_out(cs_n), .io_in(io_i), .io_out(io_o), .io_oe_n_out(io_oe_n));
	qsw_dev_model u_qsw_dev_model (.sck_in(sck), .cs_n_in(cs_n), .io_out_in(io_o),
		.io_oe_n_in(io_oe_n), .io_in_out(io_i));
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// Bounded poll of one status bit
	task automatic wait_st(input int b, input logic val);
		for (int n = 0; n < 400; n++) begin
			rd_reg(A_ST, v);
			if (v[b] === val)
				return;
		end
		chk("status wait", 32'(v[b]), 32'(val));
	endtask
	task automatic run(input logic [3:0] kind);
		wr_reg(A_CTL, {26'h0, 1'b1, 1'b1, kind});
		wait_st(0, 1'b0);
	endtask
	function automatic logic [7:0] cb(input int s, input int l);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < 8 / l; i++) begin
			b = (l == 1) ? {b[6:0], u_qsw_dev_model.cap[s + i][0]} :
				(l == 2) ? {b[5:0], u_qsw_dev_model.cap[s + i][1:0]} :
				{b[3:0], u_qsw_dev_model.cap[s + i]};
		end
		return b;
	endfunction
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("idle pins", {26'h0, sck, cs_n, io_oe_n}, 32'h1F);
		rd_reg(8'h1C, v);
		chk("unmapped", v, 32'h0);
		wr_reg(qsw_pkg::OFS_ADDR, 32'h0001_2345);
		wr_reg(qsw_pkg::OFS_OPC, 32'h02);
		wr_reg(A_TX, 32'hA5);
		run(4'd4);
		rd_reg(A_ST, v);
		chk("write refused", 32'(v[4:3]), 32'h1);
		wr_reg(A_CTL, 32'h40);
		run(4'd3);
		rd_reg(A_ST, v);
		chk("latch set", 32'(v[4:3]), 32'h2);
		for (int m = 0; m < 3; m++) begin
			wr_reg(A_CFG, 32'(4 + m));
			wr_reg(A_TX, 32'hA5);
			run(4'd4);
			chk("beats", u_qsw_dev_model.ncap, 40 >> m);
			for (int i = 0; i < 5; i++)
				chk("write byte", 32'(cb((8 >> m) * i, 1 << m)), 32'(SGL[39 - 8 * i -: 8]));
		end
		wr_reg(A_CFG, 32'h0);
		run(4'd6);
		rd_reg(A_ST, v);
		chk("quad refused", 32'(v[3]), 32'h1);
		wr_reg(A_CTL, 32'h40);
		wr_reg(A_CFG, 32'h4);
		for (int k = 5; k < 9; k++) begin
			al = (k < 7) ? 1 : (k == 7) ? 2 : 4;
			dl = (k % 2 == 1) ? 2 : 4;
			wr_reg(A_TX, 32'hA5);
			run(4'(k));
			chk("beats", u_qsw_dev_model.ncap, 8 + 24 / al + 8 / dl);
			for (int i = 0; i < 5; i++)
				chk("lane byte", 32'(cb(i == 0 ? 0 : 8 + (8 / al) * (i - 1),
					i == 0 ? 1 : i < 4 ? al : dl)), 32'(SGL[39 - 8 * i -: 8]));
		end
		wr_reg(A_CFG, 32'h6);
		run(4'd1);
		run(4'd3);
		run(4'd2);
		rd_reg(A_ST, v);
		chk("arm cancelled", 32'(v[5:3]), 32'h3);
		wr_reg(A_CTL, 32'h40);
		run(4'd1);
		rd_reg(A_ST, v);
		chk("armed", 32'(v[5]), 32'h1);
		run(4'd2);
		rd_reg(A_ST, v);
		chk("after reset", 32'(v[5:3]), 32'h0);
		rd_reg(A_CFG, v);
		chk("reset mode", v, 32'h4);
		wr_reg(A_CFG, 32'h6);
		run(4'd10);
		chk("recover beats", u_qsw_dev_model.ncap, 8);
		for (int i = 0; i < 8; i++)
			chk("recover lines", 32'(u_qsw_dev_model.cap[i]), 32'hF);
		rd_reg(A_CFG, v);
		chk("recover mode", v, 32'h4);
		wr_reg(A_CFG, 32'hC);
		run(4'd3);
		run(4'd4);
		rd_reg(A_ST, v);
		chk("xip write refused", 32'(v[4:3]), 32'h3);
		wr_reg(A_CTL, 32'h40);
		run(4'd11);
		chk("exit beats", u_qsw_dev_model.ncap, 8);
		chk("exit byte", 32'(cb(0, 1)), 32'hFF);
		rd_reg(A_CFG, v);
		chk("exit mode", v, 32'h4);
		wr_reg(A_TX, 32'h11);
		wr_reg(A_CTL, 32'h10);
		wait_st(1, 1'b0);
		wr_reg(A_TX, 32'h22);
		wr_reg(A_CTL, 32'h20);
		wait_st(0, 1'b0);
		chk("burst beats", u_qsw_dev_model.ncap, 24);
		for (int i = 0; i < 3; i++)
			chk("burst byte", 32'(cb(8 * i, 1)), (i == 0) ? 32'h02 : 32'(17 * i));
		wr_reg(qsw_pkg::OFS_ADDR, 32'h0F);
		wr_reg(qsw_pkg::OFS_OPC, 32'h56);
		wr_reg(A_CTL, 32'h19);
		for (int i = 0; i < 2; i++) begin
			wait_st(2, 1'b1);
			if (i == 1)
				wr_reg(A_CTL, 32'h29);
			rd_reg(qsw_pkg::OFS_RX, v);
			chk("clock reg", v, 32'(8'(8'h30 + 8'h11 * ((15 + i) % 16))));
		end
		wait_st(0, 1'b0);
		finish_test();
	end
endmodule
